/* File: rtl/isc_stop_trigger.sv */
// Added by the designer: the address map and the Wishbone slave port.
`default_nettype none
module isc_stop_trigger
(
   // system clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   // link clock for stop detection
   input  wire logic        clk_link_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // shift engine status
   input  wire logic        start_generated_i,
   input  wire logic        arb_lost_i,
   input  wire logic        tx_state_set_i,
   input  wire logic        wait9_i,
   input  wire logic        ninth_high_i,
   // engine controls
   output logic             controller_enable_o,
   output logic             ack_enable_o,
   output logic             wait_timing_select_o,
   output logic             start_trigger_o,
   output logic             leave_bus_o,
   output logic             wait_release_o,
   output logic             sda_release_o,
   output logic             scl_release_o,
   output logic             stop_seen_o,
   // serial data pin
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // serial clock pin, observed only
   input  wire logic        scl_i
);
   ////////////////////////////////////////////////////////////////////////////////
   logic                 ctrl_en;
   logic                 ack_enable;
   logic                 wait_timing_select;
   logic                 start_trigger;
   logic                 stop_trigger;
   logic                 master_state;
   logic                 transmit_state;
   logic                 stop_flag;
   logic                 first_pend;
   logic                 sda_release;
   logic                 stop_done;
   logic [7:0]           rd_byte;
   logic [isc_pkg::CNT_W-1:0] hold_cnt;
   isc_pkg::isc_seq_t    state;
   isc_pkg::isc_seq_t    next_state;
   logic                 scl_s;
   logic                 tgl_link;
   logic                 tgl_s;
   logic                 tgl_d;

   isc_sync u_scl (.clk_i(clk_sys_i), .reset_n_i(reset_n_i), .d_i(scl_i), .q_o(scl_s));
   isc_sync u_tgl (.clk_i(clk_sys_i), .reset_n_i(reset_n_i), .d_i(tgl_link), .q_o(tgl_s));
   isc_stop_det u_det
   (
      .clk_link_i (clk_link_i),
      .reset_n_i  (reset_n_i),
      .sda_i      (sda_i),
      .scl_i      (scl_i),
      .stop_tgl_o (tgl_link)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode
   wire       wb_req   = wb_cyc_i & wb_stb_i;
   wire       sel_ctrl = wb_adr_i == isc_pkg::ADDR_CTRL;
   wire       sel_stat = wb_adr_i == isc_pkg::ADDR_STAT;
   wire [7:0] wdat     = wb_dat_i[7:0];
   // writes land on the edge the master samples ack
   wire       wr_ctrl  = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0] & sel_ctrl;
   wire       wr_stop  = wr_ctrl & wdat[isc_pkg::BIT_STOP];
   wire       wr_start = wr_ctrl & wdat[isc_pkg::BIT_START];
   wire       wr_leave = wr_ctrl & wdat[isc_pkg::BIT_LEAVE];
   wire       wr_wrel  = wr_ctrl & wdat[isc_pkg::BIT_WREL];
   wire       en_next  = wr_ctrl ? wdat[isc_pkg::BIT_EN] : ctrl_en;
   wire       en_fall  = ctrl_en & ~en_next;
   wire       en_rise  = ~ctrl_en & en_next;
   wire       stop_seen = tgl_s ^ tgl_d;

   // any of these drops the trigger and aborts a running sequence
   wire clr_trig   = arb_lost_i | stop_seen | wr_leave | ~en_next;
   wire clr_master = arb_lost_i | stop_seen | wr_leave | en_fall;
   // before the first stop after enabling, the trigger acts even without master state
   wire may_master = master_state | first_pend;
   // eighth-clock wait never launches; the ninth high phase or ninth wait does
   wire go_stop    = stop_trigger & may_master & (wait9_i | ninth_high_i);
   wire tx_release = transmit_state & ninth_high_i;

   wire [7:0] ctrl_rd = {ctrl_en, 3'h0, wait_timing_select, ack_enable, 2'h0};
   wire [7:0] stat_rd = {master_state, 3'h0, transmit_state, 1'b0, state != isc_pkg::SEQ_IDLE, stop_flag};
   wire [7:0] rd_mux  = sel_ctrl ? ctrl_rd : (sel_stat ? stat_rd : 8'h00);

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         wb_ack_o <= 1'b0;
         rd_byte  <= 8'h00;
      end
      else
      begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         rd_byte  <= rd_mux;
      end
   end

   assign wb_dat_o = {24'h000000, rd_byte};

   ////////////////////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_en            <= isc_pkg::CTRL_RESET[isc_pkg::BIT_EN];
         ack_enable         <= isc_pkg::CTRL_RESET[isc_pkg::BIT_ACKE];
         wait_timing_select <= isc_pkg::CTRL_RESET[isc_pkg::BIT_WTS];
         start_trigger      <= isc_pkg::CTRL_RESET[isc_pkg::BIT_START];
         stop_trigger       <= isc_pkg::CTRL_RESET[isc_pkg::BIT_STOP];
      end
      else
      begin
         ctrl_en <= en_next;
         if (wr_ctrl)
         begin
            ack_enable         <= wdat[isc_pkg::BIT_ACKE];
            wait_timing_select <= wdat[isc_pkg::BIT_WTS];
         end
         // start trigger lives until the engine reports the start, or until disable, leave or arbitration loss
         if (~en_next | wr_leave | arb_lost_i | start_generated_i)
            start_trigger <= 1'b0;
         else if (wr_start)
            start_trigger <= 1'b1;
         // clearing events beat a same-cycle software set
         if (clr_trig)
            stop_trigger <= 1'b0;
         else if (wr_stop)
            stop_trigger <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status bits; a hardware set wins over a same-cycle clear
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         master_state   <= isc_pkg::STAT_RESET[isc_pkg::BIT_MASTER];
         transmit_state <= isc_pkg::STAT_RESET[isc_pkg::BIT_TXST];
         stop_flag      <= isc_pkg::STAT_RESET[isc_pkg::BIT_STOPSEEN];
         first_pend     <= 1'b0;
         sda_release    <= 1'b0;
         tgl_d          <= 1'b0;
      end
      else
      begin
         tgl_d          <= tgl_s;
         master_state   <= start_generated_i | (master_state & ~clr_master);
         transmit_state <= tx_state_set_i | (transmit_state & ~tx_release & ctrl_en);
         stop_flag      <= stop_seen | (stop_flag & ~start_generated_i & ctrl_en);
         first_pend     <= en_rise | (first_pend & ~stop_seen & en_next);
         sda_release    <= tx_release;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // stop sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         isc_pkg::SEQ_IDLE:
            if (go_stop & ~clr_trig)
               next_state = isc_pkg::SEQ_SDA_LOW;
         isc_pkg::SEQ_SDA_LOW:
            next_state = isc_pkg::SEQ_WAIT_SCL;
         isc_pkg::SEQ_WAIT_SCL:
            if (scl_s)
               next_state = isc_pkg::SEQ_HOLD;
         isc_pkg::SEQ_HOLD:
            if (hold_cnt == '0)
               next_state = isc_pkg::SEQ_IDLE;
         default:
            next_state = isc_pkg::SEQ_IDLE;
      endcase
      if (clr_trig)
         next_state = isc_pkg::SEQ_IDLE;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         state     <= isc_pkg::SEQ_IDLE;
         hold_cnt  <= '0;
         stop_done <= 1'b0;
      end
      else
      begin
         state <= next_state;
         // clock stays released after data rises, else the stop edge is lost
         if (clr_trig | (next_state == isc_pkg::SEQ_SDA_LOW))
            stop_done <= 1'b0;
         else if (state == isc_pkg::SEQ_HOLD && next_state == isc_pkg::SEQ_IDLE)
            stop_done <= 1'b1;
         // counted on this clock so the interval does not depend on the link rate
         if (state == isc_pkg::SEQ_WAIT_SCL)
            hold_cnt <= isc_pkg::CNT_W'(isc_pkg::STOP_SETUP_CYC - 1);
         else if (hold_cnt != '0)
            hold_cnt <= hold_cnt - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign sda_o                = 1'b0;
   assign sda_oe_o             = state != isc_pkg::SEQ_IDLE;
   assign scl_release_o        = state == isc_pkg::SEQ_WAIT_SCL || state == isc_pkg::SEQ_HOLD || stop_done;
   assign controller_enable_o  = ctrl_en;
   assign ack_enable_o         = ack_enable;
   assign wait_timing_select_o = wait_timing_select;
   assign start_trigger_o      = start_trigger;
   assign leave_bus_o          = wr_leave;
   assign wait_release_o       = wr_wrel | tx_release;
   assign sda_release_o        = sda_release;
   assign stop_seen_o          = stop_seen;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence s_hold_enter;
      state == isc_pkg::SEQ_WAIT_SCL ##1 state == isc_pkg::SEQ_HOLD;
   endsequence

   sequence s_hold_end;
      state == isc_pkg::SEQ_HOLD && hold_cnt == '0 && !clr_trig;
   endsequence

   a_no_stop_idle: assert property (
      (state == isc_pkg::SEQ_IDLE && !stop_trigger) |=> state == isc_pkg::SEQ_IDLE)
      else $error("stop sequence started without trigger");

   a_sda_low_first: assert property (
      (state == isc_pkg::SEQ_IDLE && go_stop && !clr_trig)
      |=> sda_oe_o && !sda_o && !scl_release_o ##1 scl_release_o && sda_oe_o)
      else $error("data line not driven low before clock release");

   a_hold_count: assert property (
      s_hold_enter |-> hold_cnt == isc_pkg::CNT_W'(isc_pkg::STOP_SETUP_CYC - 1) && sda_oe_o)
      else $error("setup count not loaded on hold entry");

   a_hold_release: assert property (
      s_hold_end |=> state == isc_pkg::SEQ_IDLE && !sda_oe_o)
      else $error("data line not released after setup interval");

   a_ninth_launch: assert property (
      (state == isc_pkg::SEQ_IDLE && stop_trigger && may_master && ninth_high_i && !clr_trig)
      |=> state == isc_pkg::SEQ_SDA_LOW)
      else $error("stop not launched in ninth clock high phase");

   a_arb_clear: assert property (
      arb_lost_i |=> !stop_trigger && state == isc_pkg::SEQ_IDLE)
      else $error("arbitration loss left trigger set");

   a_det_clear: assert property (
      stop_seen |=> !stop_trigger && !master_state)
      else $error("detected stop left trigger or master state");

   a_leave_clear: assert property (
      (wr_leave || (wr_ctrl && !wdat[isc_pkg::BIT_EN])) |=> !stop_trigger [*2])
      else $error("leave or disable did not clear trigger");

   a_read_zero: assert property (
      (wb_req && !wb_we_i && sel_ctrl && !wb_ack_o) |=> wb_ack_o && !wb_dat_o[isc_pkg::BIT_STOP])
      else $error("stop trigger bit read back as one");

   a_tx_release: assert property (
      tx_release && !tx_state_set_i |-> wait_release_o ##1 (!transmit_state && sda_release_o))
      else $error("transmit state not released in ninth clock");

   a_trig_held: assert property (
      (stop_trigger && !clr_trig) |=> stop_trigger)
      else $error("trigger dropped without clearing event");

   a_master_only: assert property (
      (state == isc_pkg::SEQ_IDLE && !may_master) |=> state == isc_pkg::SEQ_IDLE)
      else $error("stop sequence started outside master mode");
endmodule
`default_nettype wire

/* File: rtl/isc_pkg.sv */
`default_nettype none
package isc_pkg;
   // register byte offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;

   // control register fields
   localparam int BIT_STOP  = 0;
   localparam int BIT_START = 1;
   localparam int BIT_ACKE  = 2;
   localparam int BIT_WTS   = 3;
   localparam int BIT_WREL  = 5;
   localparam int BIT_LEAVE = 6;
   localparam int BIT_EN    = 7;

   // status register fields
   localparam int BIT_STOPSEEN = 0;
   localparam int BIT_BUSY     = 1;
   localparam int BIT_TXST     = 3;
   localparam int BIT_MASTER   = 7;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] STAT_RESET = 8'h00;

   // stop setup interval
   localparam int CLK_PERIOD_NS  = 8;
   localparam int STOP_SETUP_NS  = 4000;
   localparam int STOP_SETUP_CYC = (STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W          = 10;

   typedef enum logic [1:0]
   {
      SEQ_IDLE     = 2'h0,
      SEQ_SDA_LOW  = 2'h1,
      SEQ_WAIT_SCL = 2'h3,
      SEQ_HOLD     = 2'h2
   } isc_seq_t;
endpackage
`default_nettype wire

/* File: rtl/isc_sync.sv */
`default_nettype none
module isc_sync
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // data
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end
      else
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/isc_stop_det.sv */
`default_nettype none
module isc_stop_det
(
   // link clock and system reset level
   input  wire logic clk_link_i,
   input  wire logic reset_n_i,
   // bus lines
   input  wire logic sda_i,
   input  wire logic scl_i,
   // toggles once per detected stop
   output logic      stop_tgl_o
);
   logic rst_link_n;
   logic sda_s;
   logic scl_s;
   logic sda_prev;
   wire  stop_hit;

   isc_sync u_rst (.clk_i(clk_link_i), .reset_n_i(1'b1), .d_i(reset_n_i), .q_o(rst_link_n));
   isc_sync u_sda (.clk_i(clk_link_i), .reset_n_i(rst_link_n), .d_i(sda_i), .q_o(sda_s));
   isc_sync u_scl (.clk_i(clk_link_i), .reset_n_i(rst_link_n), .d_i(scl_i), .q_o(scl_s));

   // data rising while clock high
   assign stop_hit = scl_s & sda_s & ~sda_prev;

   always_ff @(posedge clk_link_i)
   begin
      if (!rst_link_n)
      begin
         sda_prev   <= 1'b1;
         stop_tgl_o <= 1'b0;
      end
      else
      begin
         sda_prev   <= sda_s;
         stop_tgl_o <= stop_tgl_o ^ stop_hit;
      end
   end
endmodule
`default_nettype wire

/* File: tb/isc_bus_model.sv */
`default_nettype none
module isc_bus_model
(
   // clock
   input  wire logic       clk_i,
   // from the block; stretch_i from the test
   input  wire logic       scl_release_i,
   input  wire logic       sda_oe_i,
   input  wire logic       sda_drv_i,
   input  wire logic [4:0] stretch_i,
   // resolved lines
   output logic            scl_o,
   output logic            sda_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int hold_cnt = 0;

   ////////////////////////////////////////////////////////////////////////
   // a slow slave keeps scl low for a while after the engine lets it go
   always @(posedge clk_i)
   begin
      if (!scl_release_i)
         hold_cnt <= 0;
      else if (hold_cnt < 40)
         hold_cnt <= hold_cnt + 1;
   end

   // pull-ups on both lines; the engine holds scl low between frames
   assign scl_o = scl_release_i && (hold_cnt > int'(stretch_i));
   assign sda_o = !(sda_oe_i && !sda_drv_i);
endmodule
`default_nettype wire

/* File: tb/tb_i2c_stop_condition_trigger.sv */
`default_nettype none
module tb_i2c_stop_condition_trigger;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0] AC = isc_pkg::ADDR_CTRL;
   localparam logic [3:0] AS = isc_pkg::ADDR_STAT;
   localparam int         SU = isc_pkg::STOP_SETUP_CYC;

   logic        clk_sys_i  = 1'b0;
   logic        clk_link_i = 1'b0;
   logic        reset_n_i  = 1'b0;
   logic        cyc        = 1'b0;
   logic        we         = 1'b0;
   logic [3:0]  adr        = 4'h0;
   logic [31:0] wdat       = 32'h0;
   logic [2:0]  ev         = 3'h0;
   logic        w9         = 1'b0;
   logic        nh         = 1'b0;
   logic [4:0]  stretch    = 5'h0;
   logic [31:0] lf         = 32'hE94F;
   logic [31:0] rdat, got;
   logic        ack, scl, sda, sda_oe, sda_drv, scl_rel, wrel, sda_rel, stop_seen, en, acke, wts, stt, lv;
   int          n_leave     = 0;
   int          num_errors  = 0;
   int          check_count = 0;
   int          m_ctrl      = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   // leave-bus pulses seen at the ack edge
   always @(posedge clk_sys_i)
      if (lv === 1'b1)
         n_leave <= n_leave + 1;

   // link clock offset so its edges never line up with the system clock
   initial
   begin
      #5;
      forever #24 clk_link_i = ~clk_link_i;
   end

   isc_stop_trigger isc_stop_trigger_i
   (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_link_i(clk_link_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .start_generated_i(ev[0]), .arb_lost_i(ev[1]), .tx_state_set_i(ev[2]),
      .wait9_i(w9), .ninth_high_i(nh),
      .controller_enable_o(en), .ack_enable_o(acke), .wait_timing_select_o(wts),
      .start_trigger_o(stt), .leave_bus_o(lv), .wait_release_o(wrel), .sda_release_o(sda_rel),
      .scl_release_o(scl_rel), .stop_seen_o(stop_seen),
      .sda_i(sda), .sda_o(sda_drv), .sda_oe_o(sda_oe), .scl_i(scl)
   );

   isc_bus_model isc_bus_model_i
   (
      .clk_i(clk_sys_i), .scl_release_i(scl_rel), .sda_oe_i(sda_oe), .sda_drv_i(sda_drv),
      .stretch_i(stretch), .scl_o(scl), .sda_o(sda)
   );

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge clk_sys_i);
         n++;
      end
   endtask

   // classic single cycle; the request stays put until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge clk_sys_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      @(posedge clk_sys_i);
      wait_for(ack, 1'b1, 20, n);
      got = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      // let the register updates of the ack edge settle before callers look
      @(negedge clk_sys_i);
      if (n == 20)
         num_errors++;
   endtask

   task automatic rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk(nm, {24'h000000, exp}, got);
   endtask

   task automatic pulse(input int i);
      @(posedge clk_sys_i);
      ev[i] <= 1'b1;
      @(posedge clk_sys_i);
      ev[i] <= 1'b0;
   endtask

   // offer a wait point and make sure no stop sequence starts
   task automatic no_seq(input string nm);
      logic bad;
      bad = 1'b0;
      @(posedge clk_sys_i);
      w9 <= 1'b1;
      repeat (30)
      begin
         @(posedge clk_sys_i);
         if (sda_oe !== 1'b0)
            bad = 1'b1;
      end
      w9 <= 1'b0;
      chk(nm, 32'h0, {31'h0, bad});
      $display("test %s done", nm);
   endtask

   task automatic run_stop(input logic ninth);
      int n;
      lf = lfsr_next(lf);
      stretch <= lf[4:0];
      m_ctrl = 32'h80 | (lf & 32'h0C);
      wb(1'b1, AC, 8'(m_ctrl | 1));
      @(posedge clk_sys_i);
      if (ninth)
         nh <= 1'b1;
      else
         w9 <= 1'b1;
      wait_for(sda_oe, 1'b1, 50, n);
      chk("data driven low", 32'h1, {31'h0, sda_oe});
      @(posedge clk_sys_i);
      nh <= 1'b0;
      w9 <= 1'b0;
      wait_for(scl, 1'b1, 100, n);
      chk("data low at clock high", 32'h0, {31'h0, sda});
      wait_for(sda_oe, 1'b0, 700, n);
      chk("setup interval", 32'h1, {31'h0, (n >= SU && n <= SU + 6)});
      wait_for(stop_seen, 1'b1, 100, n);
      chk("stop detected", 32'h1, {31'h0, stop_seen});
      rd("ctrl after stop", AC, 8'(m_ctrl));
      rd("stat after stop", AS, 8'h01);
      chk("ack enable", {31'h0, lf[2]}, {31'h0, acke});
      chk("wait timing", {31'h0, lf[3]}, {31'h0, wts});
      $display("test stop ninth=%0d done", ninth);
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // about 1500 cycles of work; generous margin before giving up
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      num_errors++;
      final_report;
   end

   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rd("ctrl reset", AC, 8'h00);
      rd("stat reset", AS, 8'h00);
      wb(1'b1, 4'h8, 8'h81);
      rd("unmapped", 4'h8, 8'h00);
      rd("ctrl untouched", AC, 8'h00);
      $display("test registers done");
      wb(1'b1, AC, 8'h80);
      chk("enable", 32'h1, {31'h0, en});
      no_seq("idle trigger");
      run_stop(1'b0);
      no_seq("cleared by stop");
      wb(1'b1, AC, 8'h82);
      chk("start trigger", 32'h1, {31'h0, stt});
      pulse(0);
      rd("master set", AS, 8'h80);
      chk("start cleared", 32'h0, {31'h0, stt});
      run_stop(1'b1);
      pulse(0);
      wb(1'b1, AC, 8'h81);
      pulse(1);
      pulse(0);
      no_seq("arbitration clears");
      pulse(0);
      wb(1'b1, AC, 8'hC1);
      rd("leave reads zero", AC, 8'h80);
      chk("leave pulse", 32'h1, n_leave);
      pulse(0);
      no_seq("leave clears");
      wb(1'b1, AC, 8'h01);
      chk("disabled", 32'h0, {31'h0, en});
      no_seq("disable clears");
      wb(1'b1, AC, 8'h80);
      pulse(2);
      rd("transmit state", AS, 8'h08);
      @(posedge clk_sys_i);
      nh <= 1'b1;
      @(negedge clk_sys_i);
      chk("wait release", 32'h1, {31'h0, wrel});
      @(posedge clk_sys_i);
      nh <= 1'b0;
      @(negedge clk_sys_i);
      chk("data release", 32'h1, {31'h0, sda_rel});
      rd("transmit cleared", AS, 8'h00);
      $display("test transmit done");
      final_report;
   end
endmodule
`default_nettype wire
